// ### core/nvm_ctrl.sv
// Local design decisions: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ns
module nvm_ctrl #(
  parameter int CYCLE_LEN = nvm_pkg::CYCLE_LEN_DEFAULT
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic stack_full,
  input wire logic irq_ack,
  output logic irq_req
);
  import nvm_pkg::*;

  localparam int CNT_W = $clog2(CYCLE_LEN) + 1;

  if (CYCLE_LEN < 1) begin : g_bad_len
    $error("CYCLE_LEN must be at least 1");
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [3:0] sat_inc(input logic [3:0] ofs);
    sat_inc = (ofs == OFFSET_LAST) ? OFFSET_LAST : ofs + 4'h1;
  endfunction

  logic wait_q;
  logic [31:0] rdata_q;
  ctrl_type ctrl_q;
  logic [6:0] addr_q;
  logic [7:0] data_q;
  logic [7:0] buf_q [0:PAGE_BYTES-1];
  logic [PAGE_BYTES-1:0] valid_q;
  logic full_q;
  logic wr_fresh_q;
  logic erase_fresh_q;
  logic warm_prev_q;
  logic earm_prev_q;
  state_type state_q;
  logic [CNT_W-1:0] cnt_q;
  logic ie_q;
  logic gie_q;
  logic flag_q;
  logic irq_q;
  logic [7:0] mem_q [0:(1<<ADDR_W)-1];

  logic acc;
  logic wr_acc;
  logic idle;
  logic ctrl_wr;
  logic addr_wr;
  logic data_wr;
  logic irq_wr;
  logic buf_wr;
  logic buf_clr;
  ctrl_type new_c;
  logic [7:0] wbyte;
  logic erase_go;
  logic write_go;
  logic read_go;
  logic op_done;
  logic done_evt;
  logic [2:0] page;
  logic [3:0] ofs;

  assign page = addr_q[6:4];
  assign ofs = addr_q[3:0];
  assign acc = (avs_read || avs_write) && !wait_q;
  assign wr_acc = avs_write && !wait_q && avs_byteenable[0];
  assign idle = (state_q == st_idle);
  assign wbyte = avs_writedata[7:0];
  assign new_c = ctrl_type'(avs_writedata[6:0]);
  assign ctrl_wr = wr_acc && (avs_address == OFS_CTRL) && idle;
  assign addr_wr = wr_acc && (avs_address == OFS_ADDR) && idle;
  assign data_wr = wr_acc && (avs_address == OFS_DATA) && idle;
  assign irq_wr = wr_acc && (avs_address == OFS_IRQ);

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= !((avs_read || avs_write) && wait_q);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h00000000;
    end else if (avs_read && wait_q) begin
      case (avs_address)
        OFS_CTRL: rdata_q <= {25'h0, ctrl_q};
        OFS_ADDR: rdata_q <= {25'h0, addr_q};
        OFS_DATA: rdata_q <= {24'h0, data_q};
        OFS_IRQ: rdata_q <= {29'h0, flag_q, gie_q, ie_q};
        default: rdata_q <= 32'h00000000;
      endcase
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;

  // ----------------------------------------
  // Arm and start handshake
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_fresh_q <= 1'b0;
      erase_fresh_q <= 1'b0;
    end else if (acc) begin
      wr_fresh_q <= ctrl_wr && new_c.write_arm && !ctrl_q.write_arm;
      erase_fresh_q <= ctrl_wr && new_c.erase_arm && !ctrl_q.erase_arm;
    end
  end

  assign erase_go = ctrl_wr && new_c.erase_start && new_c.erase_arm && ctrl_q.erase_arm
                    && erase_fresh_q && new_c.mode;
  assign write_go = ctrl_wr && new_c.write_start && new_c.write_arm && ctrl_q.write_arm
                    && wr_fresh_q && !erase_go;
  assign read_go = ctrl_wr && new_c.read_start && new_c.read_arm && ctrl_q.read_arm
                   && !erase_go && !write_go;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_q <= new_c;
      ctrl_q.erase_start <= erase_go;
      ctrl_q.write_start <= write_go;
      ctrl_q.read_start <= read_go;
    end else if (op_done) begin
      case (state_q)
        st_read: ctrl_q.read_start <= 1'b0;
        st_erase: begin
          ctrl_q.erase_start <= 1'b0;
          ctrl_q.erase_arm <= 1'b0;
        end
        st_write: begin
          ctrl_q.write_start <= 1'b0;
          ctrl_q.write_arm <= 1'b0;
        end
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  // ----------------------------------------
  // Cycle timer
  // ----------------------------------------
  assign op_done = !idle && (cnt_q == '0);
  assign done_evt = op_done && (state_q != st_read);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= st_idle;
    end else if (erase_go) begin
      state_q <= st_erase;
    end else if (write_go) begin
      state_q <= st_write;
    end else if (read_go) begin
      state_q <= st_read;
    end else if (op_done) begin
      state_q <= st_idle;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (erase_go || write_go || read_go) begin
      cnt_q <= CNT_W'(CYCLE_LEN - 1);
    end else if (!idle && cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  // ----------------------------------------
  // Address and data registers
  // ----------------------------------------
  assign buf_wr = data_wr && ctrl_q.mode && !full_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      addr_q <= ADDR_RESET;
    end else if (addr_wr) begin
      addr_q <= wbyte[6:0];
    end else if (buf_wr || (op_done && state_q == st_read && ctrl_q.mode)) begin
      addr_q <= {page, sat_inc(ofs)};
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      full_q <= 1'b0;
    end else if (addr_wr || buf_clr) begin
      full_q <= 1'b0;
    end else if (buf_wr && ofs == OFFSET_LAST) begin
      full_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      data_q <= DATA_RESET;
    end else if (op_done && state_q == st_read) begin
      data_q <= mem_q[addr_q];
    end else if (data_wr && !(ctrl_q.mode && full_q)) begin
      data_q <= wbyte;
    end
  end

  // ----------------------------------------
  // Page buffer
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      warm_prev_q <= 1'b0;
      earm_prev_q <= 1'b0;
    end else begin
      warm_prev_q <= ctrl_q.write_arm;
      earm_prev_q <= ctrl_q.erase_arm;
    end
  end

  assign buf_clr = (warm_prev_q && !ctrl_q.write_arm) || (earm_prev_q && !ctrl_q.erase_arm);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      valid_q <= '0;
      for (int i = 0; i < PAGE_BYTES; i++) begin
        buf_q[i] <= 8'h00;
      end
    end else begin
      if (buf_clr) begin
        valid_q <= '0;
        for (int i = 0; i < PAGE_BYTES; i++) begin
          buf_q[i] <= 8'h00;
        end
      end
      if (buf_wr) begin
        buf_q[ofs] <= wbyte;
        valid_q[ofs] <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Nonvolatile array
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (op_done && state_q == st_erase) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        mem_q[{page, OFFSET_W'(i)}] <= 8'h00;
      end
    end else if (op_done && state_q == st_write && ctrl_q.mode) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (valid_q[i]) begin
          mem_q[{page, OFFSET_W'(i)}] <= buf_q[i];
        end
      end
    end else if (op_done && state_q == st_write) begin
      // Erase and program fold into one overwrite
      mem_q[addr_q] <= data_q;
    end
  end

  // ----------------------------------------
  // Interrupt request
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flag_q <= 1'b0;
    end else if (done_evt) begin
      flag_q <= 1'b1;
    end else if (irq_ack) begin
      flag_q <= 1'b0;
    end else if (irq_wr) begin
      flag_q <= wbyte[IRQ_FLAG_BIT];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gie_q <= 1'b0;
      ie_q <= 1'b0;
    end else begin
      if (irq_ack) begin
        gie_q <= 1'b0;
      end else if (irq_wr) begin
        gie_q <= wbyte[IRQ_GIE_BIT];
      end
      if (irq_wr) begin
        ie_q <= wbyte[IRQ_EN_BIT];
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= gie_q && ie_q && flag_q && !stack_full && !irq_ack;
    end
  end

  assign irq_req = irq_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_MODE_GATES_BUF: assert property (@(posedge core_clk) disable iff (rst)
    (data_wr && !ctrl_q.mode && !buf_clr) |=> (valid_q == $past(valid_q))
      && (addr_q == $past(addr_q)))
    else $error("byte mode data write touched page buffer");

  AST_BUF_CLEARED: assert property (@(posedge core_clk) disable iff (rst)
    ($fell(ctrl_q.write_arm) && !buf_wr) |=> (valid_q == '0))
    else $error("page buffer not cleared after arm fell");

  AST_PAGE_KEPT: assert property (@(posedge core_clk) disable iff (rst)
    buf_wr |=> (addr_q[6:4] == $past(addr_q[6:4]))
      && (addr_q[3:0] == sat_inc($past(addr_q[3:0]))))
    else $error("offset step wrong or page changed");

  AST_OFFSET_SAT: assert property (@(posedge core_clk) disable iff (rst)
    full_q |-> (ofs == OFFSET_LAST) && !buf_wr)
    else $error("offset left the page end or write accepted");

  AST_START_NEEDS_ARM: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == st_write && $past(state_q) == st_idle) |-> $past(ctrl_q.write_arm)
      && $past(wr_fresh_q))
    else $error("write cycle began without arm");

  AST_CYCLE_LEN: assert property (@(posedge core_clk) disable iff (rst)
    write_go |=> (cnt_q == CNT_W'(CYCLE_LEN - 1)) && (state_q == st_write))
    else $error("write timer not loaded");

  AST_WRITE_END: assert property (@(posedge core_clk) disable iff (rst)
    (op_done && state_q == st_write) |=> !ctrl_q.write_start && !ctrl_q.write_arm
      && flag_q ##2 (valid_q == '0))
    else $error("write end did not clear bits, flag or buffer");

  AST_READ_END: assert property (@(posedge core_clk) disable iff (rst)
    (op_done && state_q == st_read) |=> !ctrl_q.read_start && (data_q == mem_q[$past(addr_q)]))
    else $error("read end wrong");

  AST_IRQ_GATE: assert property (@(posedge core_clk) disable iff (rst)
    irq_req |-> $past(gie_q && ie_q && flag_q && !stack_full))
    else $error("interrupt raised without enables");

  AST_ACK_CLEARS: assert property (@(posedge core_clk) disable iff (rst)
    (irq_ack && !done_evt) |=> !flag_q && !gie_q && !irq_req)
    else $error("service did not clear flag and enable");

endmodule // nvm_ctrl

// ### core/nvm_pkg.sv
// How it works
// - Page write only when mode bit set
// - Sixteen-byte page buffer committed together
// - Power-on reset clears the page buffer
// - Write-arm falling clears buffer; rising does not
// - Address: upper three page, lower four offset
// - Data writes advance offset only, never page
// - Offset saturates at 0xF; later writes ignored
// - Data byte stored at current offset first
// - Write or erase start must directly follow the arm write
// - Start without arm begins no cycle
// - Internal timer times the nonvolatile cycle
// - Write-start clears itself when cycle ends
// - Write-arm cleared by hardware after write
// - Write-arm resets to zero at power-on
// - Done flag set when erase or write ends
// - Vector only if enables set, stack free
// - Servicing clears done flag and global enable
// - Control bits: read, write, mode, erase positions
// - Read needs arm; start clears, data loaded
// - Page erase zeroes page, clears both bits
// - Byte write erases target before programming
package nvm_pkg;

  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_ADDR = 4'h4;
  localparam logic [3:0] OFS_DATA = 4'h8;
  localparam logic [3:0] OFS_IRQ = 4'hC;

  localparam int ADDR_W = 7;
  localparam int OFFSET_W = 4;
  localparam int PAGE_BYTES = 16;
  localparam logic [3:0] OFFSET_LAST = 4'hF;

  localparam int IRQ_EN_BIT = 0;
  localparam int IRQ_GIE_BIT = 1;
  localparam int IRQ_FLAG_BIT = 2;

  localparam int CYCLE_LEN_DEFAULT = 20;

  localparam logic [6:0] ADDR_RESET = 7'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // Bit 6 down to bit 0 of the control register
  typedef struct packed {
    logic erase_arm;
    logic erase_start;
    logic mode;
    logic write_arm;
    logic write_start;
    logic read_arm;
    logic read_start;
  } ctrl_type;

  localparam ctrl_type CTRL_RESET = 7'h00;

  typedef enum logic [1:0] {
    st_idle,
    st_read,
    st_erase,
    st_write
  } state_type;

endpackage

// ### tb/data_eeprom_page_write_ctrl_bench.sv
`timescale 1ns/1ns
module data_eeprom_page_write_ctrl_bench;
  import nvm_pkg::*;
  logic core_clk, rst, avs_read, avs_write, avs_waitrequest, stack_full, irq_ack, irq_req;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [32:0] exp_q[$];
  logic [7:0] b[4];
  logic [2:0] pg;
  int bad_count, samples_checked;

  nvm_ctrl #(.CYCLE_LEN(3)) dut (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .stack_full(stack_full), .irq_ack(irq_ack),
    .irq_req(irq_req));
  nvm_cpu_model #(.ACK_DELAY(2)) cpu (.core_clk(core_clk), .rst(rst), .irq_req(irq_req),
    .irq_ack(irq_ack));

  // ----
  // Bus tasks and result monitor
  // ----
  task automatic fail(input string m);
    bad_count++;
    $display("MISMATCH %0t %s", $time, m);
  endtask

  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
    input logic [32:0] e);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    if (!w) exp_q.push_back(e);
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 40) begin
      fail("bus hang");
      conclude();
    end
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 33'h0);
  endtask

  task automatic rx(input logic [3:0] a, input logic [7:0] v);
    bus(1'b0, a, 8'h00, {1'b1, 24'h0, v});
  endtask

  task automatic chk(input logic g, input logic x);
    samples_checked++;
    if (g !== x) fail("irq request");
  endtask

  // Arm, start next access, poll start bit
  task automatic go(input logic [6:0] m, input int ab);
    int n;
    wr(OFS_IRQ, 8'h00);
    wr(OFS_CTRL, 8'(m | (7'h1 << ab)));
    wr(OFS_CTRL, 8'(m | (7'h3 << (ab - 1))));
    n = 0;
    do begin
      bus(1'b0, OFS_CTRL, 8'h00, 33'h0);
      n++;
    end while (rd[ab - 1] !== 1'b0 && n < 60);
    if (n >= 60) begin
      fail("cycle hang");
      conclude();
    end
  endtask

  always @(posedge core_clk) begin
    logic [32:0] e;
    if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (e[32]) begin
        samples_checked++;
        if (avs_readdata !== e[31:0]) fail("read data");
      end
    end
  end

  // ----
  // Clock and test sequence
  // ----
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  initial begin
    int n;
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    stack_full = 1'b0;
    void'($urandom(32'h9AA2AEB8));
    pg = 3'($urandom());
    for (int i = 0; i < 4; i++) b[i] = 8'($urandom());
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rx(OFS_CTRL, 8'h00);
    rx(OFS_IRQ, 8'h00);
    wr(4'h2, 8'hFF);
    rx(4'h2, 8'h00);
    avs_byteenable <= 4'hE;
    wr(OFS_ADDR, 8'h7F);
    avs_byteenable <= 4'hF;
    rx(OFS_ADDR, 8'h00);
    $display("test reset done");
    wr(OFS_CTRL, 8'h04);
    rx(OFS_CTRL, 8'h00);
    wr(OFS_CTRL, 8'h08);
    rx(OFS_CTRL, 8'h08);
    wr(OFS_CTRL, 8'h0C);
    rx(OFS_CTRL, 8'h08);
    wr(OFS_CTRL, 8'h00);
    $display("test arm done");
    wr(OFS_ADDR, {1'b0, pg, 4'h0});
    go(7'h10, 6);
    rx(OFS_CTRL, 8'h10);
    rx(OFS_IRQ, 8'h04);
    wr(OFS_ADDR, {1'b0, pg, 4'hD});
    for (int i = 0; i < 4; i++) wr(OFS_DATA, b[i]);
    rx(OFS_ADDR, {1'b0, pg, 4'hF});
    rx(OFS_DATA, b[2]);
    go(7'h10, 3);
    rx(OFS_CTRL, 8'h10);
    rx(OFS_IRQ, 8'h04);
    $display("test page write done");
    stack_full <= 1'b1;
    wr(OFS_IRQ, 8'h07);
    repeat (4) @(posedge core_clk);
    chk(irq_req, 1'b0);
    rx(OFS_IRQ, 8'h07);
    stack_full <= 1'b0;
    n = 0;
    while (irq_ack !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 20) fail("no vector");
    chk(irq_req, 1'b1);
    rx(OFS_IRQ, 8'h01);
    $display("test interrupt done");
    wr(OFS_ADDR, {1'b0, pg, 4'hC});
    for (int i = 0; i < 5; i++) begin
      go(7'h10, 1);
      rx(OFS_DATA, i == 0 ? 8'h00 : b[(i > 3) ? 2 : i - 1]);
    end
    $display("test page read done");
    wr(OFS_CTRL, 8'h00);
    wr(OFS_ADDR, {1'b0, ~pg, 4'h5});
    wr(OFS_DATA, b[3]);
    go(7'h00, 3);
    rx(OFS_CTRL, 8'h00);
    wr(OFS_DATA, 8'h00);
    go(7'h00, 1);
    rx(OFS_DATA, b[3]);
    $display("test byte write done");
    wr(OFS_CTRL, 8'h10);
    wr(OFS_ADDR, {1'b0, pg, 4'h0});
    wr(OFS_DATA, b[0] | 8'h01);
    wr(OFS_CTRL, 8'h18);
    wr(OFS_CTRL, 8'h10);
    go(7'h10, 3);
    wr(OFS_ADDR, {1'b0, pg, 4'h0});
    go(7'h10, 1);
    rx(OFS_DATA, 8'h00);
    $display("test buffer clear done");
    conclude();
  end
endmodule // data_eeprom_page_write_ctrl_bench

// ### tb/nvm_cpu_model.sv
`timescale 1ns/1ns
module nvm_cpu_model #(
  parameter int ACK_DELAY = 2
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic irq_req,
  output logic irq_ack
);
  // ----
  // Vector taken after a short delay
  // ----
  int wait_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wait_q <= 0;
      irq_ack <= 1'b0;
    end else begin
      irq_ack <= 1'b0;
      if (irq_req && !irq_ack) begin
        wait_q <= wait_q + 1;
        if (wait_q >= ACK_DELAY) begin
          irq_ack <= 1'b1;
          wait_q <= 0;
        end
      end
    end
  end
endmodule // nvm_cpu_model
